// ===== hdl/cbsi_top.sv
// Multiplexed external bus sequencer with bus status byte, AXI4-Lite controlled
// Summary of operation
// - Address bits 16..9 then 8..1 leave on eight pins, middle byte first.
// - Multiplexed low address pins float while an external agent holds the bus.
// - High address shares low data lines; status byte shares high data lines.
// - Writes drive shared address, status and data with the low-address timing.
// - Reads float shared drivers; memory drives read data onto those lines.
// - High address and status stand valid across the falling row strobe edge for latching.
// - Status S1 int grant, S2 bus grant, S3 last, S4 reset, S7 renew, S8 firmware.
// - Interrupt grant bit raised; controller answers on the low eight data lines.
// - Bus grant bit announces hold entry at the end of the present cycle.
// - In hold, strobes keep running and status is driven during the row phase.
// - In hold, data, address and write strobes float outside the status phase.
// - Last-instruction bit is high on the final bus cycle of an instruction.
// - Peripheral reset bit goes low only for a system reset instruction.
// - Processor reset input never drives the peripheral reset bit low.
// - Opcode-fetch bit marks program-counter fetches into the instruction queue.
// - Operand-fetch bit marks addresses produced by instruction execution.
// - Memory-renew bit is high during every refresh cycle.
// - Firmware-fetch bit is high during every external microcode fetch.
// - Low hold request floats address and data; strobes and status keep going.
// - Low ready freezes the cycle with both strobes low until ready returns.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cbsi_top import cbsi_pkg::*; #(
  parameter int DIV = PHASE_CYC,
  parameter int AW = 8
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, low
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [7:0] mux_addr_o, // Middle then low address
  output logic mux_addr_oe_n, // Low while driving
  input wire logic [15:0] ad_i, // Shared lines, sensed
  output logic [15:0] ad_o, // Shared lines, driven
  output logic ad_lo_oe_n, // Low byte enable, low drives
  output logic ad_hi_oe_n, // High byte enable, low drives
  output logic row_strobe_n, // Row strobe, low active
  output logic col_strobe_n, // Column strobe, low active
  output logic bus_clk_o, // Bus clock
  output logic write_strobe_even_byte_n, // Even byte write, low
  output logic write_strobe_odd_byte_n, // Odd byte write, low
  output logic write_strobe_oe_n, // Low while driving strobes
  input wire logic mem_ready, // Memory ready, low stalls
  input wire logic bus_hold_request_n, // Hold request, low
  input wire logic bus_fault_input_n, // Bus fault, low
  input wire logic opcode_cancel_input_n // Instruction cancel, low
);

  function automatic logic [31:0] merge_bytes(logic [31:0] o, logic [31:0] n,
                                              logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Phase divider
  logic [15:0] div_cnt;
  wire tick = (div_cnt == 16'(DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // AXI write channel
  logic aw_have;
  logic w_have;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_do = aw_have & w_have & ~s_axi_bvalid;
  wire next_aw_have = (aw_have | aw_take) & ~wr_do;
  wire next_w_have = (w_have | w_take) & ~wr_do;
  wire wsel_addr = (wr_addr == REG_ADDR);
  wire wsel_wdata = (wr_addr == REG_WDATA);
  wire wsel_ctrl = (wr_addr == REG_CTRL);
  wire wsel_stat = (wr_addr == REG_STAT);
  wire wsel_rdata = (wr_addr == REG_RDATA);
  wire wr_hit = wsel_addr | wsel_wdata | wsel_ctrl | wsel_stat | wsel_rdata;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      s_axi_awready <= ~next_aw_have;
      s_axi_wready <= ~next_w_have;
      if (aw_take) begin
        wr_addr <= s_axi_awaddr[7:0];
      end
      if (w_take) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Command registers
  logic [31:0] cmd_addr;
  logic [31:0] cmd_wdata;
  logic [31:0] cmd_ctrl;
  logic pending;
  logic fault_flag;
  logic cancel_flag;
  logic [15:0] read_data;
  wire [31:0] ctrl_new = merge_bytes(cmd_ctrl, wr_data, wr_strb);
  wire launch = wr_do & wsel_ctrl & ~pending & (|wr_strb[1:0]);
  wire clr_fault = wr_do & wsel_stat & wr_strb[0] & wr_data[STAT_FAULT];
  wire clr_cancel = wr_do & wsel_stat & wr_strb[0] & wr_data[STAT_CANCEL];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_addr <= 32'h0000_0000;
      cmd_wdata <= 32'h0000_0000;
      cmd_ctrl <= 32'h0000_0000;
    end else if (wr_do && !pending) begin
      if (wsel_addr) begin
        cmd_addr <= merge_bytes(cmd_addr, wr_data, wr_strb) & 32'h00ff_ffff;
      end
      if (wsel_wdata) begin
        cmd_wdata <= merge_bytes(cmd_wdata, wr_data, wr_strb) & 32'h0000_ffff;
      end
      if (wsel_ctrl) begin
        cmd_ctrl <= ctrl_new & 32'h0000_07ff;
      end
    end
  end

  // Sequencer state
  cbsi_phase_t phase;
  logic in_hold;
  logic announce;
  logic active;
  cbsi_cmd_t cur;
  wire cyc_end = tick & (phase == PH_WAIT) & mem_ready;
  wire hold_req = ~bus_hold_request_n;
  wire next_in_hold = announce | (in_hold & hold_req);
  wire load = cyc_end & ~next_in_hold & pending;

  cbsi_cmd_t pend_cmd;
  always_comb begin
    pend_cmd.addr = cmd_addr[23:0];
    pend_cmd.wdata = cmd_wdata[15:0];
    pend_cmd.write = cmd_ctrl[CTRL_WRITE];
    pend_cmd.be_even = cmd_ctrl[CTRL_BE_EVEN];
    pend_cmd.be_odd = cmd_ctrl[CTRL_BE_ODD];
    // Control bit for reset instruction is inverted onto the low-active flag
    pend_cmd.stat = cmd_ctrl[CTRL_STAT_LSB +: 8] ^ STATUS_IDLE;
    pend_cmd.stat.bus_grant_flag = hold_req;
  end

  cbsi_status_t hold_stat;
  always_comb begin
    hold_stat = STATUS_IDLE;
    hold_stat.bus_grant_flag = 1'b1;
  end

  cbsi_status_t idle_stat;
  always_comb begin
    idle_stat = STATUS_IDLE;
    idle_stat.bus_grant_flag = hold_req;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 1'b0;
    end else if (launch) begin
      pending <= 1'b1;
    end else if (load) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= PH_SETUP;
    end else if (tick) begin
      case (phase)
        PH_SETUP: phase <= PH_ROW;
        PH_ROW: phase <= PH_COL;
        PH_COL: phase <= PH_WAIT;
        PH_WAIT: phase <= mem_ready ? PH_SETUP : PH_WAIT;
        default: phase <= PH_SETUP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_hold <= 1'b0;
      announce <= 1'b0;
      active <= 1'b0;
      cur <= '0;
      cur.stat <= STATUS_IDLE;
    end else if (cyc_end) begin
      in_hold <= next_in_hold;
      announce <= ~next_in_hold & hold_req;
      active <= load;
      if (next_in_hold) begin
        cur.stat <= hold_stat;
      end else if (pending) begin
        cur <= pend_cmd;
      end else begin
        cur.stat <= idle_stat;
      end
    end
  end

  // Error and cancel inputs, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_flag <= 1'b0;
      cancel_flag <= 1'b0;
    end else begin
      fault_flag <= (cyc_end & ~bus_fault_input_n) | (fault_flag & ~clr_fault);
      cancel_flag <= (tick & ~opcode_cancel_input_n) | (cancel_flag & ~clr_cancel);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_data <= 16'h0000;
    end else if (cyc_end && active && !cur.write) begin
      read_data <= ad_i;
    end
  end

  // Pin values
  wire row_half = (phase == PH_SETUP) | (phase == PH_ROW);
  wire drive_cmd = active & ~in_hold;
  wire drive_data = drive_cmd & cur.write & ~row_half;
  wire [7:0] next_mux_addr = row_half ? cur.addr[16:9] : cur.addr[8:1];
  wire [7:0] next_ad_lo = row_half ? cur.addr[23:16] : cur.wdata[7:0];
  wire [7:0] next_ad_hi = row_half ? cur.stat : cur.wdata[15:8];
  wire next_ad_lo_oe_n = ~(drive_cmd & (row_half | drive_data));
  wire next_ad_hi_oe_n = ~(row_half | drive_data);
  wire next_row_n = (phase == PH_SETUP);
  wire next_col_n = row_half;
  wire next_we_even_n = ~(drive_cmd & cur.write & cur.be_even);
  wire next_we_odd_n = ~(drive_cmd & cur.write & cur.be_odd);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_addr_o <= 8'h00;
      mux_addr_oe_n <= 1'b1;
      ad_o <= {STATUS_IDLE, 8'h00};
      ad_lo_oe_n <= 1'b1;
      ad_hi_oe_n <= 1'b1;
      row_strobe_n <= 1'b1;
      col_strobe_n <= 1'b1;
      bus_clk_o <= 1'b0;
      write_strobe_even_byte_n <= 1'b1;
      write_strobe_odd_byte_n <= 1'b1;
      write_strobe_oe_n <= 1'b1;
    end else begin
      mux_addr_o <= next_mux_addr;
      mux_addr_oe_n <= ~drive_cmd;
      ad_o <= {next_ad_hi, next_ad_lo};
      ad_lo_oe_n <= next_ad_lo_oe_n;
      ad_hi_oe_n <= next_ad_hi_oe_n;
      row_strobe_n <= next_row_n;
      col_strobe_n <= next_col_n;
      bus_clk_o <= (phase == PH_WAIT);
      write_strobe_even_byte_n <= next_we_even_n;
      write_strobe_odd_byte_n <= next_we_odd_n;
      write_strobe_oe_n <= in_hold;
    end
  end

  // Status flags of the running cycle come from the command, with S4 inverted and bus grant from the hold request

  // AXI read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rsel_addr = (ra == REG_ADDR);
  wire rsel_wdata = (ra == REG_WDATA);
  wire rsel_ctrl = (ra == REG_CTRL);
  wire rsel_stat = (ra == REG_STAT);
  wire rsel_rdata = (ra == REG_RDATA);
  wire rd_hit = rsel_addr | rsel_wdata | rsel_ctrl | rsel_stat | rsel_rdata;
  wire [31:0] stat_word = {28'h0000000, cancel_flag, fault_flag, in_hold,
                           pending | active};
  wire [31:0] rd_mux = rsel_addr ? cmd_addr :
                       rsel_wdata ? cmd_wdata :
                       rsel_ctrl ? cmd_ctrl :
                       rsel_stat ? stat_word :
                       rsel_rdata ? {16'h0000, read_data} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

endmodule
`default_nettype wire

// ===== include/cbsi_pkg.sv
// Constants, register map and carrier types for the bus status interface
package cbsi_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PHASE_NS = 125;
  // Longest phase time, rounded down to whole cycles
  localparam int PHASE_CYC = (PHASE_NS / CLK_PERIOD_NS) < 1 ? 1 : PHASE_NS / CLK_PERIOD_NS;

  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;

  localparam int CTRL_WRITE = 0;
  localparam int CTRL_BE_EVEN = 1;
  localparam int CTRL_BE_ODD = 2;
  localparam int CTRL_STAT_LSB = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_HOLD = 1;
  localparam int STAT_FAULT = 2;
  localparam int STAT_CANCEL = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Bit 0 is S1 and leaves on data line 8
  typedef struct packed {
    logic firmware_fetch_flag;
    logic memory_renew_flag;
    logic operand_fetch_flag;
    logic opcode_fetch_flag;
    logic peripheral_reset_flag;
    logic last_instr_cycle_flag;
    logic bus_grant_flag;
    logic interrupt_grant_flag;
  } cbsi_status_t;

  localparam cbsi_status_t STATUS_IDLE = 8'h08;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic write;
    logic be_odd;
    logic be_even;
    cbsi_status_t stat;
  } cbsi_cmd_t;

  typedef enum logic [1:0] {PH_SETUP, PH_ROW, PH_COL, PH_WAIT} cbsi_phase_t;
endpackage

// ===== tb/cbsi_chk.sv
// Bus status sequencer pin checker
`timescale 1ns/1ps
`default_nettype none
module cbsi_chk #(
  parameter int DIV = 2
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic mux_addr_oe_n, // Address enable
  input wire logic [15:0] ad_o, // Shared lines out
  input wire logic ad_lo_oe_n, // Low byte enable
  input wire logic ad_hi_oe_n, // High byte enable
  input wire logic row_strobe_n, // Row strobe
  input wire logic col_strobe_n, // Column strobe
  input wire logic write_strobe_even_byte_n, // Even write
  input wire logic write_strobe_odd_byte_n, // Odd write
  input wire logic write_strobe_oe_n, // Strobe enable
  input wire logic mem_ready // Memory ready
);
  int rl;
  wire logic no_wr = write_strobe_even_byte_n & write_strobe_odd_byte_n;
  // Length of the current row strobe
  always_ff @(posedge aclk) begin
    if (!aresetn || row_strobe_n) rl <= 0;
    else rl <= rl + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence row_open;
    $fell(row_strobe_n);
  endsequence
  sequence col_open;
    $fell(col_strobe_n);
  endsequence
  a_col_in_row: assert property (!col_strobe_n |-> !row_strobe_n)
    else $error("column strobe without row strobe");
  a_status_row: assert property (row_open |-> !ad_hi_oe_n)
    else $error("status not driven at row strobe");
  a_hold_float: assert property (write_strobe_oe_n |-> mux_addr_oe_n && ad_lo_oe_n)
    else $error("address driven in hold");
  a_hold_grant: assert property (write_strobe_oe_n && !ad_hi_oe_n |-> ad_o[9])
    else $error("hold status lacks bus grant");
  a_ready_freeze: assert property ($rose(col_strobe_n) |-> $past(mem_ready, 2))
    else $error("strobes released while not ready");
  a_write_drive: assert property (col_open ##0 !no_wr |-> !ad_lo_oe_n && !ad_hi_oe_n)
    else $error("write data not driven");
  a_read_float: assert property (!col_strobe_n && no_wr && !mux_addr_oe_n
    |-> ad_lo_oe_n && ad_hi_oe_n)
    else $error("read lines driven");
  a_row_width: assert property ($rose(row_strobe_n) |-> rl >= 3 * DIV)
    else $error("row strobe too short");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_reset_s4: assert property (disable iff (1'b0) !aresetn |=> ad_o[11] && ad_hi_oe_n)
    else $error("reset disturbed peripheral reset bit");
endmodule
bind cbsi_top cbsi_chk #(.DIV(DIV)) u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .mux_addr_oe_n, .ad_o, .ad_lo_oe_n, .ad_hi_oe_n, .row_strobe_n, .col_strobe_n,
  .write_strobe_even_byte_n, .write_strobe_odd_byte_n, .write_strobe_oe_n, .mem_ready);
`default_nettype wire

// ===== tb/cbsi_mem.sv
// Memory, latches and interrupt controller on the far side
`timescale 1ns/1ps
`default_nettype none
module cbsi_mem (
  input wire logic aclk, // Clock
  input wire logic row_strobe_n, // Row strobe
  input wire logic col_strobe_n, // Column strobe
  input wire logic bus_clk_o, // Bus clock
  input wire logic [7:0] mux_addr_o, // Multiplexed address
  input wire logic mux_addr_oe_n, // Address enable
  input wire logic [15:0] ad_o, // Device drive
  input wire logic ad_lo_oe_n, // Low byte enable
  input wire logic ad_hi_oe_n, // High byte enable
  input wire logic [1:0] wr_n, // Odd, even write strobes
  input wire logic [3:0] stall, // Wait cycles asked
  output logic [15:0] ad_i, // Wire level
  output logic mem_ready, // Ready, low stalls
  output logic [23:0] seen_addr, // Latched address
  output logic [7:0] seen_stat, // Command status
  output logic [7:0] bus_stat, // Any cycle status
  output logic [15:0] seen_wdata, // Written data
  output logic [1:0] seen_we, // Odd, even enables
  output logic [7:0] cmds // Command cycles seen
);
  logic prow = 1'b1;
  logic pcol = 1'b1;
  logic pbclk = 1'b0;
  logic cmd = 1'b0;
  logic [15:0] rd = 16'h0;
  logic [3:0] sc = 4'h0;
  wire logic mdrv = !col_strobe_n && cmd && (&wr_n);
  // Released lines show the inverse of the last data
  assign ad_i[7:0] = !ad_lo_oe_n ? ad_o[7:0] : mdrv ? rd[7:0] : ~rd[7:0];
  assign ad_i[15:8] = !ad_hi_oe_n ? ad_o[15:8] : mdrv ? rd[15:8] : ~rd[15:8];
  assign mem_ready = sc == 4'h0;
  initial cmds = 8'h0;
  always @(posedge aclk) begin
    prow <= row_strobe_n;
    pcol <= col_strobe_n;
    pbclk <= bus_clk_o;
    if (prow && !row_strobe_n && !ad_hi_oe_n) begin
      bus_stat <= ad_o[15:8];
      cmd <= !mux_addr_oe_n;
      if (!mux_addr_oe_n) begin
        seen_stat <= ad_o[15:8];
        seen_addr[23:9] <= {ad_o[7:0], mux_addr_o[6:0]};
        rd <= {ad_o[7:0], ad_o[8] ? 8'h3c : 8'hc3};
      end
    end
    if (pcol && !col_strobe_n) begin
      sc <= stall;
      if (cmd) seen_addr[8:0] <= {mux_addr_o, 1'b0};
    end else if (sc != 4'h0) sc <= sc - 4'h1;
    if (!pbclk && bus_clk_o && cmd) begin
      seen_we <= ~wr_n;
      if (!(&wr_n)) seen_wdata <= ad_o;
      cmds <= cmds + 8'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/cbsi_top_bench.sv
// Self-checking bench for the bus status sequencer
`timescale 1ns/1ps
`default_nettype none
module cbsi_top_bench;
  import cbsi_pkg::*;
  typedef struct {
    logic [10:0] ctrl;
    logic [23:0] addr;
    logic [15:0] wd;
    logic [3:0] stall;
    logic [15:0] rd;
  } cbsi_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, c0;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb, stall;
  logic [1:0] r;
  logic bus_hold_request_n, bus_fault_input_n, opcode_cancel_input_n;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, seen_we;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] mux_addr_o, seen_stat, bus_stat, cmds;
  wire logic [15:0] ad_i, ad_o, seen_wdata;
  wire logic [23:0] seen_addr;
  wire logic mux_addr_oe_n, ad_lo_oe_n, ad_hi_oe_n, row_strobe_n, col_strobe_n, bus_clk_o;
  wire logic write_strobe_even_byte_n, write_strobe_odd_byte_n, write_strobe_oe_n, mem_ready;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  cbsi_row_t rows [7] = '{
    '{11'h027, 24'h123456, 16'hbeef, 4'h0, 16'h0},
    '{11'h080, 24'habcdef, 16'h0, 4'h0, 16'habc3},
    '{11'h100, 24'h5a0102, 16'h0, 4'h5, 16'h5ac3},
    '{11'h203, 24'h00fffe, 16'h1234, 4'h0, 16'h0},
    '{11'h400, 24'hff0000, 16'h0, 4'h0, 16'hffc3},
    '{11'h045, 24'h7e0010, 16'h55aa, 4'h0, 16'h0},
    '{11'h008, 24'h010203, 16'h0, 4'h0, 16'h013c}};
  cbsi_top #(.DIV(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mux_addr_o,
    .mux_addr_oe_n, .ad_i, .ad_o, .ad_lo_oe_n, .ad_hi_oe_n, .row_strobe_n, .col_strobe_n,
    .bus_clk_o, .write_strobe_even_byte_n, .write_strobe_odd_byte_n, .write_strobe_oe_n,
    .mem_ready, .bus_hold_request_n, .bus_fault_input_n, .opcode_cancel_input_n);
  cbsi_mem u_mem (.aclk, .row_strobe_n, .col_strobe_n, .bus_clk_o, .mux_addr_o, .mux_addr_oe_n,
    .ad_o, .ad_lo_oe_n, .ad_hi_oe_n, .wr_n({write_strobe_odd_byte_n, write_strobe_even_byte_n}),
    .stall, .ad_i, .mem_ready, .seen_addr, .seen_stat, .bus_stat, .seen_wdata, .seen_we, .cmds);
  function automatic logic [7:0] xstat(input logic [10:0] c);
    return {c[10], c[9], c[8], c[7], ~c[6], c[5], 1'b0, c[3]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, stall} = '0;
    s_axi_wstrb = 4'hf;
    {bus_hold_request_n, bus_fault_input_n, opcode_cancel_input_n} = 3'h7;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      stall <= rows[i].stall;
      axw(REG_ADDR, {8'h0, rows[i].addr}, r);
      axw(REG_WDATA, {16'h0, rows[i].wd}, r);
      c0 = cmds;
      axw(REG_CTRL, {21'h0, rows[i].ctrl}, r);
      wait (cmds != c0);
      wait (mem_ready);
      repeat (6) @(posedge aclk);
      chk("status", xstat(rows[i].ctrl), seen_stat);
      chk("address", {rows[i].addr[23:1], 1'b0}, seen_addr);
      if (rows[i].ctrl[0]) begin
        chk("wdata", rows[i].wd, seen_wdata);
        chk("enables", rows[i].ctrl[2:1], seen_we);
      end else begin
        axr(REG_RDATA, d, r);
        chk("rdata", rows[i].rd, d[15:0]);
      end
    end
    bus_hold_request_n <= 1'b0;
    do axr(REG_STAT, d, r); while (d[STAT_HOLD] !== 1'b1);
    c0 = cmds;
    axw(REG_CTRL, 32'h80, r);
    repeat (40) @(posedge aclk);
    axr(REG_STAT, d, r);
    chk("hold busy", 2'b11, d[1:0]);
    chk("hold grant", 1'b1, bus_stat[1]);
    chk("hold idle", c0, cmds);
    bus_hold_request_n <= 1'b1;
    wait (cmds != c0);
    chk("after hold", xstat(11'h080), seen_stat);
    bus_fault_input_n <= 1'b0;
    opcode_cancel_input_n <= 1'b0;
    repeat (24) @(posedge aclk);
    bus_fault_input_n <= 1'b1;
    opcode_cancel_input_n <= 1'b1;
    axr(REG_STAT, d, r);
    chk("sticky", 2'b11, d[3:2]);
    axw(REG_STAT, 32'hc, r);
    axr(REG_STAT, d, r);
    chk("cleared", 2'b00, d[3:2]);
    axr(8'h20, d, r);
    chk("unmapped rresp", RESP_DECERR, r);
    chk("unmapped rdata", 32'h0, d);
    axw(8'h24, 32'h1, r);
    chk("unmapped bresp", RESP_DECERR, r);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("reset status", 8'h08, ad_o[15:8]);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(REG_STAT, d, r);
    chk("reset busy", 1'b0, d[0]);
    end_of_test;
  end
endmodule
`default_nettype wire
